// File: rtl/asp_cfg.svh
// offsets, field positions, reset values and codes of the audio packer
// assumes a 32-bit AXI4-Lite slave with byte addresses in the low 8 bits
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_CTRL_OFS 8'h00
`define ASP_SPK_OFS 8'h04
`define ASP_STAT_OFS 8'h08
`define ASP_LANE_LSB 0
`define ASP_CH_LSB 4
`define ASP_WID_LSB 8
`define ASP_CTRL_RST 32'h0000_1812
`define ASP_SPK_RST 32'h0000_0000
`define ASP_MK_BLK 2'h0
`define ASP_MK_SF1 2'h1
`define ASP_MK_SF2 2'h2
`define ASP_SLOT_PAR 3'h4
`define ASP_RESP_OK 2'h0
`define ASP_RESP_ERR 2'h2
`endif

// File: rtl/asp_pkg.sv
// types shared by the audio stream payload packer
// assumes asp_cfg.svh for the numeric constants
package asp_pkg;
  typedef struct packed {
    logic [23:0] word;
    logic p;
    logic c;
    logic u;
    logic v;
  } chan_s;
  typedef struct packed {
    chan_s [7:0] ch;
    logic blk_start;
    logic present;
  } sample_s;
  typedef enum logic {ST_IDLE, ST_SEND} pack_state_e;
  typedef logic [3:0][7:0] lanes_t;
endpackage : asp_pkg

// File: rtl/audio_stream_payload_packer.sv
// audio stream packet payload packer: one sample in, lane byte rows out
// assumes the link takes one row per clock and adds header and parity
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "asp_cfg.svh"
// Contract
// - speaker allocation follows infoframe byte four
// - four data bytes then parity per lane
// - one channel per group, channels five-eight follow
// - bytes 0-2 sample word, msb byte2 bit7
// - narrow samples zero-padded in low bits
// - byte3 bits0-3 validity user status parity
// - byte3 bits5:4 hold subframe marker code
// - byte3 bit6 always zero
// - byte3 bit7 marks sample present
// - all groups of a sample share the present bit
// - unused lanes two-three flagged absent
// - packet never ends inside a sample
module audio_stream_payload_packer import asp_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sample_s in_sample,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic close_req,
  output lanes_t lane_byte,
  output logic [3:0] lane_en,
  output logic [2:0] slot,
  output logic out_valid,
  output logic sample_end,
  output logic packet_end,
  output logic [7:0] speaker_allocation_value
);
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, spk_r, spk_nxt;
  logic [15:0] count_r, count_nxt;

  // software side: control, speaker allocation, status
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    spk_nxt = spk_r;
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_got_r && w_got_r && !bvalid_r) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (awaddr_r == `ASP_CTRL_OFS || awaddr_r == `ASP_SPK_OFS) ?
        `ASP_RESP_OK : `ASP_RESP_ERR;
      for (int i = 0; i < 4; i++) begin
        if (wstrb_r[i] && awaddr_r == `ASP_CTRL_OFS) begin
          ctrl_nxt[8*i+:8] = wdata_r[8*i+:8];
        end
        if (wstrb_r[i] && awaddr_r == `ASP_SPK_OFS) begin
          spk_nxt[8*i+:8] = wdata_r[8*i+:8];
        end
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    awready_nxt = !aw_got_nxt;
    wready_nxt = !w_got_nxt;
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `ASP_RESP_OK;
      case (s_axi_araddr)
        `ASP_CTRL_OFS: rdata_nxt = ctrl_r;
        `ASP_SPK_OFS: rdata_nxt = spk_r;
        `ASP_STAT_OFS: rdata_nxt = {count_r, 15'h0000, in_ready};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `ASP_RESP_ERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `ASP_RESP_OK;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `ASP_RESP_OK;
      ctrl_r <= `ASP_CTRL_RST;
      spk_r <= `ASP_SPK_RST;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      spk_r <= spk_nxt;
    end
  end

  pack_state_e st_r, st_nxt;
  sample_s smp_r, smp_nxt;
  logic [1:0] lsh_r, lsh_nxt;
  logic [2:0] nch_r, nch_nxt, row_r, row_nxt, blk_r, blk_nxt, last_blk, glog;
  logic [4:0] wid_r, wid_nxt;
  logic [23:0] mask;
  logic [7:0] lb [4];
  lanes_t lane_r, lane_nxt;
  logic [3:0] le, en_r, en_nxt;
  logic [2:0] slot_r, slot_nxt;
  logic ov_r, ov_nxt, se_r, se_nxt, pe_r, pe_nxt, rdy_r, rdy_nxt;
  logic [7:0] spk_out_r;

  // two groups per sample up to two channels, eight otherwise
  assign glog = (nch_r < 3'h2) ? 3'h1 : 3'h3;
  assign last_blk = (glog > 3'(lsh_r)) ?
    3'((4'h1 << (glog - 3'(lsh_r))) - 4'h1) : 3'h0;
  assign mask = ~(24'hFF_FFFF >> wid_r);

  for (genvar l = 0; l < 4; l++) begin : g_lane
    logic [4:0] g;
    logic used, in_smp;
    chan_s ch;
    logic [23:0] w;
    logic [1:0] mk;
    assign g = 5'((5'(blk_r) << lsh_r) + 5'(l));
    assign in_smp = g < ((nch_r < 3'h2) ? 5'h02 : 5'h08);
    assign used = g <= 5'(nch_r);
    assign ch = smp_r.ch[g[2:0]];
    assign w = used ? (ch.word & mask) : 24'h00_0000;
    // odd groups are second subframes, even ones first
    assign mk = g[0] ? `ASP_MK_SF2 :
      ((smp_r.blk_start && in_smp) ? `ASP_MK_BLK : `ASP_MK_SF1);
    assign le[l] = (st_r == ST_SEND) && (l < (1 << lsh_r));
    always_comb begin
      case (row_r)
        3'h0: lb[l] = w[7:0];
        3'h1: lb[l] = w[15:8];
        3'h2: lb[l] = w[23:16];
        // absent pair on lanes two-three keeps present bit low
        3'h3: lb[l] = {in_smp && smp_r.present, 1'b0, mk,
          used ? {ch.p, ch.c, ch.u, ch.v} : 4'h0};
        default: lb[l] = 8'h00; // parity filled downstream
      endcase
    end
  end

  always_comb begin
    st_nxt = st_r;
    smp_nxt = smp_r;
    lsh_nxt = lsh_r;
    nch_nxt = nch_r;
    wid_nxt = wid_r;
    row_nxt = row_r;
    blk_nxt = blk_r;
    count_nxt = count_r;
    se_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (in_valid && rdy_r) begin
          st_nxt = ST_SEND;
          smp_nxt = in_sample;
          // lane code 3 treated as four lanes
          lsh_nxt = (ctrl_r[`ASP_LANE_LSB+:2] == 2'h3) ? 2'h2 :
            ctrl_r[`ASP_LANE_LSB+:2];
          nch_nxt = ctrl_r[`ASP_CH_LSB+:3];
          wid_nxt = ctrl_r[`ASP_WID_LSB+:5];
          row_nxt = 3'h0;
          blk_nxt = 3'h0;
        end
      end
      ST_SEND: begin
        row_nxt = row_r + 3'h1;
        if (row_r == `ASP_SLOT_PAR) begin
          row_nxt = 3'h0;
          blk_nxt = blk_r + 3'h1;
          if (blk_r == last_blk) begin
            st_nxt = ST_IDLE;
            se_nxt = 1'b1;
            count_nxt = count_r + 16'h0001;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    for (int i = 0; i < 4; i++) begin
      lane_nxt[i] = le[i] ? lb[i] : 8'h00;
    end
    en_nxt = le;
    slot_nxt = row_r;
    ov_nxt = st_r == ST_SEND;
    pe_nxt = se_nxt && close_req;
    // new samples only between samples, so a close never splits one
    rdy_nxt = st_nxt == ST_IDLE;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      smp_r <= '0;
      lsh_r <= 2'h0;
      nch_r <= 3'h0;
      wid_r <= 5'h00;
      row_r <= 3'h0;
      blk_r <= 3'h0;
      count_r <= 16'h0000;
      lane_r <= '0;
      en_r <= 4'h0;
      slot_r <= 3'h0;
      ov_r <= 1'b0;
      se_r <= 1'b0;
      pe_r <= 1'b0;
      rdy_r <= 1'b0;
      spk_out_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      smp_r <= smp_nxt;
      lsh_r <= lsh_nxt;
      nch_r <= nch_nxt;
      wid_r <= wid_nxt;
      row_r <= row_nxt;
      blk_r <= blk_nxt;
      count_r <= count_nxt;
      lane_r <= lane_nxt;
      en_r <= en_nxt;
      slot_r <= slot_nxt;
      ov_r <= ov_nxt;
      se_r <= se_nxt;
      pe_r <= pe_nxt;
      rdy_r <= rdy_nxt;
      spk_out_r <= spk_r[7:0];
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign in_ready = rdy_r;
  assign lane_byte = lane_r;
  assign lane_en = en_r;
  assign slot = slot_r;
  assign out_valid = ov_r;
  assign sample_end = se_r;
  assign packet_end = pe_r;
  assign speaker_allocation_value = spk_out_r;

  property p_group;
    ov_r && slot_r == 3'h0 |-> ##1 slot_r == 3'h1 ##1 slot_r == 3'h2
      ##1 slot_r == 3'h3 ##1 slot_r == `ASP_SLOT_PAR;
  endproperty
  a_group: assert property (p_group) else $error("group not 4+1");
  property p_end_par;
    se_r |-> ov_r && slot_r == `ASP_SLOT_PAR && $past(st_r) == ST_SEND;
  endproperty
  a_end_par: assert property (p_end_par) else $error("bad end");
  property p_msb;
    ov_r && slot_r == 3'h2 && wid_r == 5'h00 |-> lane_r[0] == 8'h00;
  endproperty
  a_msb: assert property (p_msb) else $error("word not masked");
  property p_pad;
    ov_r && slot_r == 3'h0 && wid_r <= 5'h10 |-> lane_r == '0;
  endproperty
  a_pad: assert property (p_pad) else $error("low bits not zero");
  property p_rsv;
    ov_r && slot_r == 3'h3 |-> !lane_r[0][6] && !lane_r[3][6];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_sf2;
    ov_r && slot_r == 3'h3 && en_r[1] |-> lane_r[1][5:4] == `ASP_MK_SF2;
  endproperty
  a_sf2: assert property (p_sf2) else $error("lane1 marker");
  property p_sp;
    ov_r && slot_r == 3'h3 |-> lane_r[0][7] == smp_r.present;
  endproperty
  a_sp: assert property (p_sp) else $error("present bit wrong");
  property p_same;
    ov_r && slot_r == 3'h3 && en_r[1] |-> lane_r[1][7] == lane_r[0][7];
  endproperty
  a_same: assert property (p_same) else $error("present differs");
  property p_close;
    pe_r |-> se_r ##1 !ov_r;
  endproperty
  a_close: assert property (p_close) else $error("split sample");
endmodule : audio_stream_payload_packer

// File: tb/audio_sink_model.sv
// sink side model: counts groups flagged present, drops the rest
// assumes packer rows, slot 3 carrying the flag byte
`timescale 1ns/10ps
module audio_sink_model import asp_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire lanes_t lane_byte,
  input wire logic [3:0] lane_en,
  input wire logic [2:0] slot,
  input wire logic out_valid,
  output logic [15:0] kept_r
);
  logic [15:0] kept_nxt;
  always_comb begin
    kept_nxt = kept_r;
    if (out_valid && slot == 3'h3) begin
      for (int l = 0; l < 4; l++) begin
        // absent groups never reach the audio output
        if (lane_en[l] && lane_byte[l][7]) begin
          kept_nxt = kept_nxt + 16'h1;
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) kept_r <= 16'h0;
    else kept_r <= kept_nxt;
  end
endmodule : audio_sink_model

// File: tb/testbench.sv
// self-checking bench of the audio payload packer
// assumes asp_cfg.svh offsets and the sink model beside the packer
`timescale 1ns/10ps
`include "asp_cfg.svh"
module testbench import asp_pkg::*;;
  logic clock = 1'b0;
  logic reset_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, speaker_allocation_value;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, lane_en;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, in_valid, in_ready, close_req;
  logic out_valid, sample_end, packet_end;
  logic [2:0] slot;
  logic [15:0] kept_r;
  sample_s in_sample;
  lanes_t lane_byte;
  integer seed = 38459;
  integer err_total = 0;
  integer cmp_count = 0;
  integer exp_kept = 0;
  // last entry is the only single-channel case, with twelve-bit samples
  int lc_t[8] = '{0, 1, 2, 2, 1, 3, 2, 0};
  int cc_t[8] = '{1, 1, 1, 7, 7, 7, 2, 0};
  int wd_t[8] = '{24, 16, 24, 20, 24, 0, 24, 12};
  always #2 clock = ~clock;
  audio_stream_payload_packer i_dut (.*);
  audio_sink_model i_sink (.*);
  task summarize;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task axi_wr(input logic [7:0] a, input logic [31:0] d,
              output logic [1:0] r);
    bit aw, w;
    @(posedge clock);
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // returns {compare mask, expected byte}
  function automatic logic [15:0] exp_b(sample_s s, int g, int r, int nch,
                                        int gs, int w);
    chan_s c;
    logic [23:0] wd;
    logic [1:0] mk;
    c = (g < nch) ? s.ch[g] : '0;
    wd = c.word & ~((24'h1 << (24 - w)) - 24'h1);
    mk = (g % 2) ? `ASP_MK_SF2 : (s.blk_start ? `ASP_MK_BLK : `ASP_MK_SF1);
    case (r)
      0: return {8'hFF, wd[7:0]};
      1: return {8'hFF, wd[15:8]};
      2: return {8'hFF, wd[23:16]};
      // unused channels: only present and reserved bits are fixed
      3: return {(g < nch) ? 8'hFF : 8'hC0, s.present && g < gs, 1'b0, mk,
                 c.p, c.c, c.u, c.v};
      default: return 16'hFF00;
    endcase
  endfunction : exp_b
  task send(input int lc, input int nch, input int w, input bit cl);
    sample_s s;
    int nl, gs, rows, g;
    logic [15:0] e;
    for (int i = 0; i < 8; i++) s.ch[i] = 28'($random(seed));
    s.blk_start = 1'($random(seed));
    s.present = ({$random(seed)} % 4) != 0;
    nl = lc == 0 ? 1 : (lc == 1 ? 2 : 4);
    gs = nch <= 2 ? 2 : 8;
    rows = 5 * (gs > nl ? gs / nl : 1);
    @(posedge clock);
    in_sample <= s;
    in_valid <= 1'b1;
    close_req <= cl;
    do @(posedge clock); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    // first row leaves the packer one edge after the accept edge
    @(posedge clock);
    for (int r = 0; r < rows; r++) begin
      #1;
      chk(out_valid === 1'b1 && slot === 3'(r % 5) &&
          lane_en === 4'((1 << nl) - 1), "row framing");
      chk(in_ready === (r == rows - 1) && sample_end === (r == rows - 1) &&
          packet_end === (cl && r == rows - 1), "sample end");
      for (int l = 0; l < 4; l++) begin
        g = (r / 5) * nl + l;
        e = l < nl ? exp_b(s, g, r % 5, nch, gs, w) : 16'hFF00;
        chk(((lane_byte[l] ^ e[7:0]) & e[15:8]) === 8'h00, "lane byte");
      end
      @(posedge clock);
    end
    if (s.present) exp_kept += gs;
  endtask : send
  initial begin
    #40000;
    err_total++;
    $display("unexpected at %0t: watchdog", $time);
    summarize;
  end
  initial begin
    logic [31:0] d, q;
    logic [1:0] r;
    reset_n <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    in_sample <= '0;
    in_valid <= 1'b0;
    close_req <= 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    axi_rd(`ASP_CTRL_OFS, d, r);
    chk(d === `ASP_CTRL_RST && r === `ASP_RESP_OK, "ctrl reset");
    axi_rd(`ASP_SPK_OFS, d, r);
    chk(d === `ASP_SPK_RST && r === `ASP_RESP_OK, "spk reset");
    axi_rd(8'h40, d, r);
    chk(d === 32'h0 && r === `ASP_RESP_ERR, "unmapped read");
    axi_wr(8'h40, 32'hFFFF_FFFF, r);
    chk(r === `ASP_RESP_ERR, "unmapped write");
    repeat (4) begin
      d = $random(seed);
      axi_wr(`ASP_SPK_OFS, d, r);
      repeat (2) @(posedge clock);
      chk(speaker_allocation_value === d[7:0], "speaker value");
    end
    // byte strobes: only the upper three bytes of the inverse land
    s_axi_wstrb <= 4'hE;
    axi_wr(`ASP_SPK_OFS, ~d, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(`ASP_SPK_OFS, q, r);
    chk(q === {~d[31:8], d[7:0]} && r === `ASP_RESP_OK, "byte strobe");
    chk(speaker_allocation_value === d[7:0], "speaker kept");
    for (int k = 0; k < 8; k++) begin
      axi_wr(`ASP_CTRL_OFS, 32'((wd_t[k] << 8) | (cc_t[k] << 4) | lc_t[k]), r);
      for (int n = 0; n < 3; n++) send(lc_t[k], cc_t[k] + 1, wd_t[k], n == 2);
      chk(kept_r === 16'(exp_kept), "sink count");
    end
    axi_rd(`ASP_STAT_OFS, d, r);
    chk(d[0] === 1'b1 && d[31:16] === 16'd24, "status");
    summarize;
  end
endmodule : testbench
